// File: rtl/spmc_config.v
// Master mode, alarm and parity configuration bank of a three-channel path transceiver.
// Summary of operation
// - Single-stream bit selects one STS-1 at 6.48 MHz, else STS-3 at 19.44 MHz.
// - Single-stream mode silences channel 2 and 3 outputs and ignores their inputs.
// - Concatenation bit selects STS-3c payloads; no effect in single-stream mode.
// - Concatenated mode silences channel 2 and 3 outputs and ignores their inputs.
// - Marker disable removes the multiframe mark from composite timing outputs.
// - External termination takes RECEIVE bus data; otherwise payload flag and parity ignored.
// - Monitor select makes justification counters watch receive stream, else DROP bus.
// - Receive bypass, refused in external termination, skips receive elastic store and locks DROP to receive stream.
// - Transmit bypass skips transmit elastic store and locks transmit frame to ADD.
// - Trace mismatch or unstable inserts DROP path AIS only when enabled.
// - Enabled loss of multiframe inserts tributary AIS, sparing overhead and pointers.
// - Enabled loss of pointer inserts DROP path AIS.
// - Label mismatch or unstable inserts DROP path AIS only when enabled.
// - Select 00 takes FEBE/FERF from local receiver; 11 reports neither.
// - Select 01 carries FEBE/FERF reported over the transmit alarm port.
// - Select 10 builds new G1 in receiver; transmit passes ADD FEBE/FERF.
// - Timing and payload flags join bus parity only when their include bits are set.
// - RECEIVE and ADD parity checked odd when check sense high, else even.
// - DROP, GENERATED and TRANSMIT parity generated odd or even per generate sense.
// - Enabled ADD parity errors drive the active-low interrupt.
// - ADD parity error sets status; reading parity register clears it and interrupt.
// - RECEIVE parity error sets status; interrupts only while its enable is high.
`timescale 1ns/1ps
`default_nettype none
`include "spmc_regs.vh"
module spmc_config #(
  parameter DATA_W = 8,
  parameter CHANNELS = 3
) (
  input wire mclk,
  input wire rst,
  input wire [8:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  input wire receive_input_clock,
  input wire [DATA_W-1:0] receive_data,
  input wire receive_payload_flag,
  input wire receive_composite_timing,
  input wire receive_bus_parity,
  input wire add_bus_clock,
  input wire [DATA_W-1:0] add_data,
  input wire add_payload_flag,
  input wire add_composite_timing,
  input wire add_bus_parity,
  input wire [DATA_W-1:0] drop_data,
  input wire drop_payload_flag,
  input wire [DATA_W-1:0] gen_data,
  input wire gen_payload_flag,
  input wire [DATA_W-1:0] tx_data,
  input wire tx_payload_flag,
  input wire [2:0] frame_spe_mark,
  input wire [2:0] multiframe_mark,
  input wire [CHANNELS-1:0] overhead_out_raw,
  input wire [CHANNELS-1:0] overhead_in_raw,
  input wire [CHANNELS-1:0] defect_tim,
  input wire [CHANNELS-1:0] defect_tiu,
  input wire [CHANNELS-1:0] defect_lom,
  input wire [CHANNELS-1:0] defect_lop,
  input wire [CHANNELS-1:0] defect_pslm,
  input wire [CHANNELS-1:0] defect_pslu,
  input wire local_febe,
  input wire local_ferf,
  input wire port_febe,
  input wire port_ferf,
  input wire add_febe,
  input wire add_ferf,
  output reg single_stream_mode,
  output reg bus_rate_slow,
  output reg concatenated_payload_select_payload_active,
  output reg [CHANNELS-1:0] overhead_out,
  output reg [CHANNELS-1:0] overhead_in,
  output reg drop_composite_timing,
  output reg generated_composite_timing,
  output reg transmit_composite_timing,
  output reg external_path_active,
  output reg receive_processor_enable,
  output reg justification_from_receive,
  output reg receive_elastic_active,
  output reg transmit_elastic_active,
  output reg [CHANNELS-1:0] drop_path_ais,
  output reg [CHANNELS-1:0] drop_trib_ais,
  output reg tx_febe,
  output reg tx_ferf,
  output reg rx_build_g1,
  output reg drop_bus_parity,
  output reg generated_bus_parity,
  output reg transmit_bus_parity,
  output reg interrupt_out_n
);

  reg [7:0] mode_configuration;
  reg [7:0] alarm_configuration;
  reg [5:0] parity_control;
  reg add_parity_irq_status;
  reg receive_parity_irq_status;
  reg [2:0] rx_clk_sync;
  reg [2:0] add_clk_sync;
  reg rx_clk_level;
  reg add_clk_level;
  reg [3*(DATA_W+3)-1:0] rx_pipe;
  reg [3*(DATA_W+3)-1:0] add_pipe;
  wire rx_rise;
  wire add_rise;
  wire [DATA_W+2:0] rx_word;
  wire [DATA_W+2:0] add_word;
  wire single;
  wire concatenated_payload_select_eff;
  wire chan23_on;
  wire ext_mode;
  wire [1:0] rx_sel;
  wire parity_read;
  wire rx_err;
  wire add_err;
  wire next_api;
  wire next_rpi;
  wire [CHANNELS-1:0] chan_on;
  wire [CHANNELS-1:0] next_path_ais;

  // Parity over a byte plus optional timing and payload flags.
  function par_sum;
    input [DATA_W-1:0] data;
    input timing;
    input payload;
    input inc_t;
    input inc_pl;
    begin
      par_sum = (^data) ^ (timing & inc_t) ^ (payload & inc_pl);
    end
  endfunction

  // Composite timing mark with the multiframe mark optionally removed.
  function comp_mark;
    input frame_spe;
    input multiframe;
    input mf_disable;
    begin
      comp_mark = frame_spe | (multiframe & ~mf_disable);
    end
  endfunction

  assign single = mode_configuration[`SPMC_M_SINGLE];
  assign concatenated_payload_select_eff = mode_configuration[`SPMC_M_CONCATENATED_PAYLOAD_SELECT] & ~single;
  // channels 2 and 3 only in STS-3 without concatenation.
  assign chan23_on = ~single & ~concatenated_payload_select_eff;
  assign chan_on = {{(CHANNELS-1){chan23_on}}, 1'b1};
  assign ext_mode = mode_configuration[`SPMC_M_EXTERNAL_TERMINATION_MODE];
  assign rx_sel = alarm_configuration[`SPMC_A_RXSEL+1:`SPMC_A_RXSEL];
  assign parity_read = reg_read & (reg_addr == `SPMC_PARITY_ADDR);

  // Bus clocks and their data pass three stages; an edge counts when stages two and three agree.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_clk_sync <= 3'h0;
      add_clk_sync <= 3'h0;
      rx_clk_level <= 1'b0;
      add_clk_level <= 1'b0;
      rx_pipe <= {3*(DATA_W+3){1'b0}};
      add_pipe <= {3*(DATA_W+3){1'b0}};
    end else begin
      rx_clk_sync <= {rx_clk_sync[1:0], receive_input_clock};
      add_clk_sync <= {add_clk_sync[1:0], add_bus_clock};
      if (rx_clk_sync[1] == rx_clk_sync[2]) begin
        rx_clk_level <= rx_clk_sync[2];
      end
      if (add_clk_sync[1] == add_clk_sync[2]) begin
        add_clk_level <= add_clk_sync[2];
      end
      rx_pipe <= {rx_pipe[2*(DATA_W+3)-1:0], receive_data, receive_payload_flag,
                  receive_composite_timing, receive_bus_parity};
      add_pipe <= {add_pipe[2*(DATA_W+3)-1:0], add_data, add_payload_flag,
                   add_composite_timing, add_bus_parity};
    end
  end

  // The data pass the same three stages as the clock, so the byte is settled when the edge is seen.
  assign rx_rise = rx_clk_sync[1] & rx_clk_sync[2] & ~rx_clk_level;
  assign add_rise = add_clk_sync[1] & add_clk_sync[2] & ~add_clk_level;
  assign rx_word = rx_pipe[3*(DATA_W+3)-1:2*(DATA_W+3)];
  assign add_word = add_pipe[3*(DATA_W+3)-1:2*(DATA_W+3)];

  // check sums including the parity bit.
  assign add_err = add_rise & ((par_sum(add_word[DATA_W+2:3], add_word[1], add_word[2],
                   parity_control[`SPMC_P_INCT], parity_control[`SPMC_P_PAYLOAD_FLAG_PARITY_INCLUDE])
                   ^ add_word[0]) != parity_control[`SPMC_P_CHKODD]);
  // receive parity only meaningful in external termination.
  assign rx_err = rx_rise & ext_mode & ((par_sum(rx_word[DATA_W+2:3], rx_word[1], rx_word[2],
                  parity_control[`SPMC_P_INCT], parity_control[`SPMC_P_PAYLOAD_FLAG_PARITY_INCLUDE])
                  ^ rx_word[0]) != parity_control[`SPMC_P_CHKODD]);

  // a new error wins over the read that clears.
  assign next_api = add_err | (add_parity_irq_status & ~parity_read);
  assign next_rpi = rx_err | (receive_parity_irq_status & ~parity_read);

  // Register writes; the reserved mode bit is stored as written and steers nothing.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_configuration <= `SPMC_MODE_RESET;
      alarm_configuration <= `SPMC_ALARM_RESET;
      parity_control <= `SPMC_PARITY_RESET;
      add_parity_irq_status <= 1'b0;
      receive_parity_irq_status <= 1'b0;
    end else begin
      add_parity_irq_status <= next_api;
      receive_parity_irq_status <= next_rpi;
      if (reg_write) begin
        case (reg_addr)
          `SPMC_MODE_ADDR: begin
            mode_configuration <= reg_wdata;
          end
          `SPMC_ALARM_ADDR: begin
            alarm_configuration <= reg_wdata;
          end
          `SPMC_PARITY_ADDR: begin
            parity_control <= {reg_wdata[`SPMC_P_RPE], reg_wdata[`SPMC_P_APE],
                               reg_wdata[`SPMC_P_GENODD:`SPMC_P_INCT]};
          end
          default: begin
            mode_configuration <= mode_configuration;
          end
        endcase
      end
    end
  end

  // Read data appear the cycle after the strobe; unmapped addresses read zero.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `SPMC_MODE_ADDR: begin
          reg_rdata <= mode_configuration;
        end
        `SPMC_ALARM_ADDR: begin
          reg_rdata <= alarm_configuration;
        end
        `SPMC_PARITY_ADDR: begin
          reg_rdata <= {receive_parity_irq_status, parity_control[5],
                        add_parity_irq_status, parity_control[4], parity_control[3:0]};
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Per-channel AIS requests, forced off on channels that are idle in this mode.
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_ais
      assign next_path_ais[ch] = chan_on[ch] &
        ((defect_tim[ch] & alarm_configuration[`SPMC_A_TIM]) |
         (defect_tiu[ch] & alarm_configuration[`SPMC_A_TIU]) |
         (defect_lop[ch] & alarm_configuration[`SPMC_A_LOP]) |
         (defect_pslm[ch] & alarm_configuration[`SPMC_A_PSLM]) |
         (defect_pslu[ch] & alarm_configuration[`SPMC_A_PSLU]));
    end
  endgenerate

  // Mode, bypass and alarm outputs, all registered.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      single_stream_mode <= 1'b0;
      bus_rate_slow <= 1'b0;
      concatenated_payload_select_payload_active <= 1'b0;
      overhead_out <= {CHANNELS{1'b0}};
      overhead_in <= {CHANNELS{1'b0}};
      external_path_active <= 1'b0;
      receive_processor_enable <= 1'b0;
      justification_from_receive <= 1'b0;
      receive_elastic_active <= 1'b1;
      transmit_elastic_active <= 1'b1;
      drop_path_ais <= {CHANNELS{1'b0}};
      drop_trib_ais <= {CHANNELS{1'b0}};
    end else begin
      single_stream_mode <= single;
      bus_rate_slow <= single;
      concatenated_payload_select_payload_active <= concatenated_payload_select_eff;
      // gate channel 2 and 3 pins.
      overhead_out <= overhead_out_raw & chan_on;
      overhead_in <= overhead_in_raw & chan_on;
      // internal processor off in external termination.
      external_path_active <= ext_mode;
      receive_processor_enable <= ~ext_mode;
      justification_from_receive <= mode_configuration[`SPMC_M_MONSEL];
      // receive bypass is refused while external termination is on.
      receive_elastic_active <= ~(mode_configuration[`SPMC_M_RXBYP] & ~ext_mode);
      transmit_elastic_active <= ~mode_configuration[`SPMC_M_TXBYP];
      drop_path_ais <= next_path_ais;
      // tributary AIS leaves overhead and pointers alone.
      drop_trib_ais <= defect_lom & chan_on &
                       {CHANNELS{alarm_configuration[`SPMC_A_LOM]}};
    end
  end

  // Timing marks, path status sourcing and generated parity.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      drop_composite_timing <= 1'b0;
      generated_composite_timing <= 1'b0;
      transmit_composite_timing <= 1'b0;
      tx_febe <= 1'b0;
      tx_ferf <= 1'b0;
      rx_build_g1 <= 1'b0;
      drop_bus_parity <= 1'b0;
      generated_bus_parity <= 1'b0;
      transmit_bus_parity <= 1'b0;
    end else begin
      drop_composite_timing <= comp_mark(frame_spe_mark[0], multiframe_mark[0],
                                         mode_configuration[`SPMC_M_MFDIS]);
      generated_composite_timing <= comp_mark(frame_spe_mark[1], multiframe_mark[1],
                                              mode_configuration[`SPMC_M_MFDIS]);
      transmit_composite_timing <= comp_mark(frame_spe_mark[2], multiframe_mark[2],
                                             mode_configuration[`SPMC_M_MFDIS]);
      rx_build_g1 <= (rx_sel == `SPMC_SEL_INBAND);
      case (rx_sel)
        `SPMC_SEL_LOCAL: begin
          tx_febe <= local_febe;
          tx_ferf <= local_ferf;
        end
        `SPMC_SEL_PORT: begin
          tx_febe <= port_febe;
          tx_ferf <= port_ferf;
        end
        `SPMC_SEL_INBAND: begin
          tx_febe <= add_febe;
          tx_ferf <= add_ferf;
        end
        default: begin
          tx_febe <= 1'b0;
          tx_ferf <= 1'b0;
        end
      endcase
      // generated parity makes the total odd or even.
      drop_bus_parity <= par_sum(drop_data, comp_mark(frame_spe_mark[0], multiframe_mark[0],
                         mode_configuration[`SPMC_M_MFDIS]), drop_payload_flag,
                         parity_control[`SPMC_P_INCT], parity_control[`SPMC_P_PAYLOAD_FLAG_PARITY_INCLUDE])
                         ^ parity_control[`SPMC_P_GENODD];
      generated_bus_parity <= par_sum(gen_data, comp_mark(frame_spe_mark[1],
                              multiframe_mark[1], mode_configuration[`SPMC_M_MFDIS]),
                              gen_payload_flag, parity_control[`SPMC_P_INCT],
                              parity_control[`SPMC_P_PAYLOAD_FLAG_PARITY_INCLUDE]) ^ parity_control[`SPMC_P_GENODD];
      transmit_bus_parity <= par_sum(tx_data, comp_mark(frame_spe_mark[2], multiframe_mark[2],
                             mode_configuration[`SPMC_M_MFDIS]), tx_payload_flag,
                             parity_control[`SPMC_P_INCT], parity_control[`SPMC_P_PAYLOAD_FLAG_PARITY_INCLUDE])
                             ^ parity_control[`SPMC_P_GENODD];
    end
  end

  // enabled sticky flags pull the interrupt low.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      interrupt_out_n <= 1'b1;
    end else begin
      interrupt_out_n <= ~((next_api & parity_control[4]) | (next_rpi & parity_control[5]));
    end
  end

endmodule
`default_nettype wire

// File: rtl/spmc_regs.vh
// Register offsets, field positions and reset values of the path master configuration bank.
`ifndef SPMC_REGS_VH
`define SPMC_REGS_VH
`define SPMC_MODE_ADDR 9'h000
`define SPMC_ALARM_ADDR 9'h001
`define SPMC_PARITY_ADDR 9'h002
`define SPMC_MODE_RESET 8'h00
`define SPMC_ALARM_RESET 8'h3f
`define SPMC_PARITY_RESET 6'h00
`define SPMC_M_SINGLE 0
`define SPMC_M_CONCATENATED_PAYLOAD_SELECT 1
`define SPMC_M_MFDIS 2
`define SPMC_M_MONSEL 4
`define SPMC_M_EXTERNAL_TERMINATION_MODE 5
`define SPMC_M_RXBYP 6
`define SPMC_M_TXBYP 7
`define SPMC_A_TIM 0
`define SPMC_A_TIU 1
`define SPMC_A_LOM 2
`define SPMC_A_LOP 3
`define SPMC_A_PSLM 4
`define SPMC_A_PSLU 5
`define SPMC_A_RXSEL 6
`define SPMC_P_INCT 0
`define SPMC_P_PAYLOAD_FLAG_PARITY_INCLUDE 1
`define SPMC_P_CHKODD 2
`define SPMC_P_GENODD 3
`define SPMC_P_APE 4
`define SPMC_P_API 5
`define SPMC_P_RPE 6
`define SPMC_P_RPI 7
`define SPMC_SEL_LOCAL 2'h0
`define SPMC_SEL_PORT 2'h1
`define SPMC_SEL_INBAND 2'h2
`endif

// File: verification/spmc_bus_model.sv
// Behavioural far-end source of one RECEIVE or ADD bus.
`timescale 1ns/1ps
`default_nettype none
module spmc_bus_model (
  output logic bus_clk,
  output logic [7:0] bus_data,
  output logic bus_pl,
  output logic bus_timing,
  output logic bus_parity
);
  // The bus clock stands low between bytes.
  initial begin
    bus_clk = 1'b0;
    bus_data = 8'h00;
    bus_pl = 1'b0;
    bus_timing = 1'b0;
    bus_parity = 1'b0;
  end
  // One byte per call; cfg is {odd, payload include, timing include}, bad spoils parity.
  task automatic send(input logic [7:0] d, input logic pl, input logic tm,
    input logic [2:0] cfg, input logic bad);
    bus_data = d;
    bus_pl = pl;
    bus_timing = tm;
    bus_parity = ^d ^ (tm & cfg[0]) ^ (pl & cfg[1]) ^ cfg[2] ^ bad;
    #200;
    bus_clk = 1'b1;
    #200;
    bus_clk = 1'b0;
    #100;
    // Released lines flip so stale values are never mistaken for a held byte.
    {bus_data, bus_pl, bus_timing, bus_parity} = ~{bus_data, bus_pl, bus_timing, bus_parity};
  endtask
endmodule
`default_nettype wire

// File: verification/spmc_config_monitor.sv
// Port-level checker for the path master configuration bank.
`timescale 1ns/1ps
`default_nettype none
module spmc_config_monitor #(
  parameter DATA_W = 8,
  parameter CHANNELS = 3
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [8:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic [2:0] frame_spe_mark,
  input wire logic [2:0] multiframe_mark,
  input wire logic [CHANNELS-1:0] defect_tim,
  input wire logic [CHANNELS-1:0] defect_tiu,
  input wire logic [CHANNELS-1:0] defect_lom,
  input wire logic [CHANNELS-1:0] defect_lop,
  input wire logic [CHANNELS-1:0] defect_pslm,
  input wire logic [CHANNELS-1:0] defect_pslu,
  input wire logic local_febe,
  input wire logic port_febe,
  input wire logic add_febe,
  input wire logic [DATA_W-1:0] drop_data,
  input wire logic drop_payload_flag,
  input wire logic concatenated_payload_select_payload_active,
  input wire logic drop_composite_timing,
  input wire logic receive_elastic_active,
  input wire logic [CHANNELS-1:0] drop_path_ais,
  input wire logic [CHANNELS-1:0] drop_trib_ais,
  input wire logic tx_febe,
  input wire logic drop_bus_parity,
  input wire logic interrupt_out_n
);
  logic [7:0] mode;
  logic [7:0] alarm;
  logic [7:0] par;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Shadows of what software wrote, so each output can be tied to its setting.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode <= 8'h00;
      alarm <= 8'h3f;
      par <= 8'h00;
    end else if (reg_write) begin
      if (reg_addr == 9'h000) mode <= reg_wdata;
      if (reg_addr == 9'h001) alarm <= reg_wdata;
      if (reg_addr == 9'h002) par <= reg_wdata;
    end
  end
  AST_CONCATENATED_PAYLOAD_SELECT: assert property ($stable(mode) |->
    concatenated_payload_select_payload_active == (mode[1] && !mode[0])) else $error("concatenated_payload_select flag wrong");
  AST_RXBYP: assert property ($stable(mode) |->
    receive_elastic_active == !(mode[6] && !mode[5])) else $error("rx store state wrong");
  AST_MARKER: assert property (!$past(rst) |-> drop_composite_timing ==
    $past(frame_spe_mark[0] | (multiframe_mark[0] & !mode[2]))) else $error("marker wrong");
  AST_AIS: assert property (!$past(rst) |-> drop_path_ais[0] == $past(|({defect_tim[0],
    defect_tiu[0], defect_lop[0], defect_pslm[0], defect_pslu[0]} &
    {alarm[0], alarm[1], alarm[3], alarm[4], alarm[5]}))) else $error("path ais wrong");
  AST_TRIB: assert property (!$past(rst) |->
    drop_trib_ais[0] == $past(defect_lom[0] & alarm[2])) else $error("trib ais wrong");
  AST_FEBE: assert property (!$past(rst) |-> tx_febe == $past(alarm[7:6] == 2'h0 ?
    local_febe : alarm[7:6] == 2'h1 ? port_febe : alarm[7:6] == 2'h2 && add_febe))
    else $error("febe source wrong");
  AST_GENPAR: assert property (!$past(rst) && !$past(par[0]) |-> drop_bus_parity ==
    $past(^drop_data ^ (drop_payload_flag & par[1]) ^ par[3])) else $error("drop parity wrong");
  AST_IRQ: assert property (!$past(par[4]) && !$past(par[4], 2) && !$past(par[6]) &&
    !$past(par[6], 2) |-> interrupt_out_n) else $error("interrupt while disabled");
endmodule
bind spmc_config spmc_config_monitor #(.DATA_W(DATA_W), .CHANNELS(CHANNELS)) u_mon (.*);
`default_nettype wire

// File: verification/tb_sonet_path_master_config.sv
// Self-checking bench for the path master configuration bank.
`timescale 1ns/1ps
`default_nettype none
module tb_sonet_path_master_config;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [8:0] reg_addr = 9'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0, reg_read = 1'b0;
  logic [7:0] drop_data = 8'h00, gen_data = 8'h00, tx_data = 8'h00;
  logic drop_payload_flag = 1'b0, gen_payload_flag = 1'b0, tx_payload_flag = 1'b0;
  logic [2:0] frame_spe_mark = 3'h0, multiframe_mark = 3'h0;
  logic [2:0] overhead_out_raw = 3'h7, overhead_in_raw = 3'h7;
  logic [2:0] defect_tim = 3'h0, defect_tiu = 3'h0, defect_lom = 3'h0;
  logic [2:0] defect_lop = 3'h0, defect_pslm = 3'h0, defect_pslu = 3'h0;
  logic local_febe = 1'b0, local_ferf = 1'b0, port_febe = 1'b0;
  logic port_ferf = 1'b0, add_febe = 1'b0, add_ferf = 1'b0;
  logic receive_input_clock, receive_payload_flag, receive_composite_timing, receive_bus_parity;
  logic add_bus_clock, add_payload_flag, add_composite_timing, add_bus_parity;
  logic [7:0] receive_data, add_data, reg_rdata, m;
  logic single_stream_mode, bus_rate_slow, concatenated_payload_select_payload_active, drop_composite_timing;
  logic generated_composite_timing, transmit_composite_timing, external_path_active;
  logic receive_processor_enable, justification_from_receive, receive_elastic_active;
  logic transmit_elastic_active, tx_febe, tx_ferf, rx_build_g1, drop_bus_parity;
  logic generated_bus_parity, transmit_bus_parity, interrupt_out_n;
  logic [2:0] overhead_out, overhead_in, drop_path_ais, drop_trib_ais;
  logic [5:0] e;
  logic [7:0] modes [10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h10, 8'h20, 8'h40, 8'h60, 8'h80, 8'h00};
  logic [2:0] fx [4] = '{3'h4, 3'h2, 3'h7, 3'h0};
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  spmc_config dut (.*);
  spmc_bus_model u_add (.bus_clk(add_bus_clock), .bus_data(add_data), .bus_pl(add_payload_flag),
    .bus_timing(add_composite_timing), .bus_parity(add_bus_parity));
  spmc_bus_model u_rx (.bus_clk(receive_input_clock), .bus_data(receive_data),
    .bus_pl(receive_payload_flag), .bus_timing(receive_composite_timing),
    .bus_parity(receive_bus_parity));
  always #25 mclk = ~mclk;
  task automatic give_verdict();
    if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // A write ends a cycle and a half after it is taken, so derived outputs have settled.
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
    repeat (2) @(negedge mclk);
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] exp, input string what);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    @(negedge mclk);
    chk(what, reg_rdata, exp);
  endtask
  task automatic snd(input logic rx, input logic [7:0] d, input logic pl, input logic tm,
    input logic [2:0] cfg, input logic bad);
    if (rx) u_rx.send(d, pl, tm, cfg, bad);
    else u_add.send(d, pl, tm, cfg, bad);
    repeat (10) @(negedge mclk);
  endtask
  task automatic wait_irq(input logic want);
    for (int k = 0; k < 20 && interrupt_out_n !== want; k++) @(negedge mclk);
    chk("interrupt", interrupt_out_n, want);
  endtask
  // A hung handshake ends the run well past the few hundred cycles expected.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    rd(9'h000, 8'h00, "mode reset");
    rd(9'h001, 8'h3f, "alarm reset");
    rd(9'h002, 8'h00, "parity reset");
    wr(9'h003, 8'hff);
    rd(9'h003, 8'h00, "unmapped read");
    wr(9'h000, 8'h97);
    rd(9'h000, 8'h97, "mode readback");
    @(posedge mclk);
    multiframe_mark <= 3'h7;
    foreach (modes[i]) begin
      m = modes[i];
      wr(9'h000, m);
      chk("mode outputs", {single_stream_mode, bus_rate_slow, concatenated_payload_select_payload_active,
        external_path_active, receive_processor_enable, justification_from_receive,
        receive_elastic_active, transmit_elastic_active, overhead_out, overhead_in,
        drop_composite_timing, generated_composite_timing, transmit_composite_timing},
        {m[0], m[0], m[1] & ~m[0], m[5], ~m[5], m[4], ~(m[6] & ~m[5]), ~m[7],
        (m[0] | m[1]) ? 6'h09 : 6'h3f, {3{~m[2]}}});
    end
    for (int i = 0; i < 7; i++) begin
      e = (i < 6) ? (6'h01 << i) : 6'h00;
      @(posedge mclk);
      {defect_tim, defect_tiu, defect_lom, defect_lop, defect_pslm, defect_pslu} <= '1;
      wr(9'h001, {2'b00, e});
      chk("ais", {drop_path_ais, drop_trib_ais},
        {(e & 6'h3b) != 6'h00 ? 3'h7 : 3'h0, e[2] ? 3'h7 : 3'h0});
      // Only the events whose enables are off are raised, so no AIS may follow.
      @(posedge mclk);
      {defect_tim, defect_tiu, defect_lom, defect_lop, defect_pslm, defect_pslu} <=
        {{3{~e[0]}}, {3{~e[1]}}, {3{~e[2]}}, {3{~e[3]}}, {3{~e[4]}}, {3{~e[5]}}};
      repeat (2) @(negedge mclk);
      chk("ais others", {drop_path_ais, drop_trib_ais}, 6'h00);
    end
    for (int v = 0; v < 8; v++) begin
      @(posedge mclk);
      {local_febe, local_ferf, port_febe, port_ferf, add_febe, add_ferf} <= v[2] ? 6'h18 : 6'h27;
      wr(9'h001, {v[1:0], 6'h00});
      chk("febe", {tx_febe, tx_ferf, rx_build_g1}, v[1:0] == 2'h3 ? 3'h0 :
        fx[v[1:0]] ^ {v[2], v[2], 1'b0});
    end
    @(posedge mclk);
    {drop_data, gen_data, tx_data} <= {3{8'h5b}};
    {drop_payload_flag, gen_payload_flag, tx_payload_flag} <= 3'h7;
    frame_spe_mark <= 3'h7;
    for (int p = 0; p < 8; p++) begin
      wr(9'h002, {4'h0, p[2], 1'b0, p[1:0]});
      chk("gen parity", {drop_bus_parity, generated_bus_parity, transmit_bus_parity},
        {3{1'b1 ^ p[0] ^ p[1] ^ p[2]}});
    end
    wr(9'h002, 8'h14);
    snd(1'b0, 8'h3c, 1'b1, 1'b0, 3'h4, 1'b0);
    chk("irq idle", interrupt_out_n, 1'b1);
    snd(1'b0, 8'h3c, 1'b1, 1'b0, 3'h4, 1'b1);
    wait_irq(1'b0);
    rd(9'h002, 8'h34, "add status");
    chk("irq cleared", interrupt_out_n, 1'b1);
    rd(9'h002, 8'h14, "add status cleared");
    wr(9'h002, 8'h17);
    snd(1'b0, 8'ha5, 1'b1, 1'b1, 3'h7, 1'b0);
    rd(9'h002, 8'h17, "included flags");
    wr(9'h002, 8'h04);
    snd(1'b0, 8'ha5, 1'b0, 1'b1, 3'h4, 1'b1);
    chk("irq masked", interrupt_out_n, 1'b1);
    rd(9'h002, 8'h24, "masked status");
    wr(9'h000, 8'h20);
    wr(9'h002, 8'h40);
    snd(1'b1, 8'h81, 1'b1, 1'b0, 3'h0, 1'b1);
    wait_irq(1'b0);
    rd(9'h002, 8'hc0, "rx status");
    wr(9'h000, 8'h00);
    snd(1'b1, 8'h81, 1'b1, 1'b0, 3'h0, 1'b1);
    rd(9'h002, 8'h40, "rx ignored");
    give_verdict();
  end
endmodule
`default_nettype wire
